/* rdi_pkg.sv */
// package: register map, field positions and carriers of the palette dac register interface
package rdi_pkg;
    // ------------------------------------------------------------
    // direct register byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] RDI_WRITE_ADDR_OFS = 16'h4000;
    localparam logic [15:0] RDI_DATA_PORT_OFS = 16'h4008;
    localparam logic [15:0] RDI_READ_MASK_OFS = 16'h4010;
    localparam logic [15:0] RDI_READ_ADDR_OFS = 16'h4018;
    localparam logic [15:0] RDI_PCOL_ADDR_OFS = 16'h4020;
    localparam logic [15:0] RDI_PCOL_DATA_OFS = 16'h4028;
    localparam logic [15:0] RDI_INDEX_LOW_OFS = 16'h4038;
    localparam logic [15:0] RDI_INDEX_HIGH_OFS = 16'h4040;
    localparam logic [15:0] RDI_INDIRECT_OFS = 16'h4050;
    localparam logic [15:0] RDI_PRAM_DATA_OFS = 16'h4058;
    localparam logic [15:0] RDI_X_LOW_OFS = 16'h4060;
    localparam logic [15:0] RDI_X_HIGH_OFS = 16'h4068;
    localparam logic [15:0] RDI_Y_LOW_OFS = 16'h4070;
    localparam logic [15:0] RDI_Y_HIGH_OFS = 16'h4078;
    localparam logic [15:0] RDI_ADDR_MASK = 16'hffff;
    // ------------------------------------------------------------
    // indirect indices
    // ------------------------------------------------------------
    localparam logic [7:0] RDI_IDX_MODE = 8'h1b;
    localparam logic [7:0] RDI_IDX_PAGE = 8'h1c;
    localparam logic [7:0] RDI_IDX_MISC = 8'h1e;
    localparam logic [7:0] RDI_IDX_PLL_M = 8'h20;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int RDI_MISC_PWR = 0;
    localparam int RDI_MISC_WIDTH = 1;
    localparam int RDI_MISC_HINV = 2;
    localparam int RDI_MISC_VINV = 3;
    localparam int RDI_MISC_PED = 4;
    localparam int RDI_MISC_SOG = 5;
    localparam logic [7:0] RDI_MISC_WMASK = 8'h3f;
    localparam int RDI_MODE_DBUF = 0;
    localparam int RDI_PIX_BUF_BIT = 31;
    localparam logic [7:0] RDI_MASK_RST = 8'hff;
    localparam logic [7:0] RDI_PAGE_RST = 8'h00;
    localparam logic [7:0] RDI_ZERO8 = 8'h00;
    localparam logic [3:0] RDI_ONE4 = 4'h1;
    localparam logic [31:0] RDI_ZERO32 = 32'h0000_0000;
    localparam int RDI_RAM_DEPTH = 2048;
    localparam int RDI_RAM_AW = 11;
    localparam logic [1:0] RDI_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] RDI_HTRANS_SEQ = 2'b11;

    // bus slave state
    typedef enum logic [1:0] {
        RDI_IDLE = 2'b00,
        RDI_RD_WAIT = 2'b01,
        RDI_RD_DONE = 2'b10
    } rdi_state_e;

    // settings sent to the display output path
    typedef struct packed {
        logic converter_power_off;
        logic lookup_entry_width;
        logic horizontal_sync_invert;
        logic vertical_sync_invert;
        logic blanking_pedestal_enable;
        logic green_channel_sync_enable;
        logic double_buffer_enable;
        logic [7:0] pixel_read_mask;
        logic [7:0] overlay_pad_page;
        logic [7:0] pixel_pll_a_multiplier;
    } rdi_ctrl_s;

    // pointer position for the overlay logic
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
    } rdi_pos_s;
endpackage : rdi_pkg

/* rdi_ram.sv */
// file: byte-wide lookup and pointer ram with registered read data
`timescale 1ns/1ns
module rdi_ram (
    input wire logic clk, // system clock
    input wire logic we, // write strobe
    input wire logic [rdi_pkg::RDI_RAM_AW-1:0] addr, // word address
    input wire logic [7:0] wdata, // write byte
    output logic [7:0] rdata // registered read byte
);
    import rdi_pkg::*;
    logic [7:0] mem [RDI_RAM_DEPTH];

    // ------------------------------------------------------------
    // storage, no reset so it maps to block ram
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : rdi_ram

/* rdi_top.sv */
// file: ahb-lite register interface of the palette dac
// Contract
// - pixel read mask is 8-bit read/write, applied before lookup, resets to ff.
// - data port at 4008 reads and writes ram at the selected address.
// - page register pads low overlay bits when fewer than eight; resets zero.
// - with double buffering enabled, pixel bit 31 picks the displayed buffer.
// - misc bit 0 set powers the converter down.
// - misc bit 1 selects 6-bit (0) or 8-bit (1) lookup entries.
// - misc bits 2 and 3 invert horizontal and vertical sync.
// - misc bit 4 adds the blanking pedestal.
// - misc bit 5 puts sync on green; bits 6 and 7 reserved.
`timescale 1ns/1ns
module rdi_top (
    input wire logic clk, // 100 mhz clock
    input wire logic rst_b, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] pixel_in, // pixel from the frame buffer
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output rdi_pkg::rdi_ctrl_s ctrl, // settings for the output path
    output rdi_pkg::rdi_pos_s pointer_pos, // committed pointer position
    output logic [7:0] masked_pixel, // masked pixel index for lookup
    output logic buffer_select // displayed buffer for this pixel
);
    import rdi_pkg::*;

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    logic ph_valid_reg;
    logic ph_write_reg;
    logic [15:0] ph_addr_reg;
    logic take;
    rdi_state_e state_reg;
    assign take = hsel && hready && (htrans == RDI_HTRANS_NONSEQ || htrans == RDI_HTRANS_SEQ);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 16'h0000;
        end else if (hready) begin
            ph_valid_reg <= take;
            ph_write_reg <= hwrite;
            ph_addr_reg <= haddr[15:0] & RDI_ADDR_MASK;
        end
    end

    logic wr_en;
    logic [7:0] wb;
    assign wr_en = ph_valid_reg && ph_write_reg;
    assign wb = hwdata[7:0];

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] wr_addr_reg;
    logic [7:0] rd_addr_reg;
    logic [7:0] pcol_addr_reg;
    logic [7:0] pcol_data_reg;
    logic [7:0] mask_reg;
    logic [7:0] index_reg;
    logic [7:0] index_high_reg;
    logic [7:0] page_reg;
    logic [7:0] misc_reg;
    logic [7:0] mode_reg;
    logic [7:0] pll_m_reg;
    logic [7:0] x_low_reg;
    logic [7:0] x_high_reg;
    logic [7:0] y_low_reg;
    logic [7:0] y_high_reg;
    logic [1:0] sub_reg;
    logic [1:0] ram_bank_reg;

    logic is_data;
    logic is_pram;
    logic is_ind;
    assign is_data = ph_valid_reg && ph_addr_reg == RDI_DATA_PORT_OFS;
    assign is_pram = ph_valid_reg && ph_addr_reg == RDI_PRAM_DATA_OFS;
    assign is_ind = ph_valid_reg && ph_addr_reg == RDI_INDIRECT_OFS;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= RDI_MASK_RST;
        end else if (wr_en && ph_addr_reg == RDI_READ_MASK_OFS) begin
            mask_reg <= wb;
        end
    end

    // address registers; data port access steps through three colour bytes per entry
    // ports step only at the edge that ends the data phase, so read waits never skip
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_addr_reg <= RDI_ZERO8;
            rd_addr_reg <= RDI_ZERO8;
            sub_reg <= 2'b00;
            ram_bank_reg <= 2'b00;
        end else if (wr_en && ph_addr_reg == RDI_WRITE_ADDR_OFS) begin
            wr_addr_reg <= wb;
            sub_reg <= 2'b00;
            ram_bank_reg <= 2'b00;
        end else if (wr_en && ph_addr_reg == RDI_READ_ADDR_OFS) begin
            rd_addr_reg <= wb;
            sub_reg <= 2'b00;
            ram_bank_reg <= 2'b00;
        end else if (is_data && hready) begin
            if (sub_reg == 2'b10) begin
                sub_reg <= 2'b00;
                if (ph_write_reg) begin
                    wr_addr_reg <= wr_addr_reg + 8'h01;
                end else begin
                    rd_addr_reg <= rd_addr_reg + 8'h01;
                end
            end else begin
                sub_reg <= sub_reg + 2'b01;
            end
        end else if (is_pram && hready) begin
            // pointer ram uses the write address as a byte counter
            {ram_bank_reg, wr_addr_reg} <= {ram_bank_reg, wr_addr_reg} + 10'h001;
        end
    end

    // pointer colour registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pcol_addr_reg <= RDI_ZERO8;
            pcol_data_reg <= RDI_ZERO8;
        end else if (wr_en && ph_addr_reg == RDI_PCOL_ADDR_OFS) begin
            pcol_addr_reg <= wb;
        end else if (wr_en && ph_addr_reg == RDI_PCOL_DATA_OFS) begin
            pcol_data_reg <= wb;
            pcol_addr_reg <= pcol_addr_reg + 8'h01;
        end
    end

    // index selection for the indirect port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= RDI_ZERO8;
            index_high_reg <= RDI_ZERO8;
        end else if (wr_en && ph_addr_reg == RDI_INDEX_LOW_OFS) begin
            index_reg <= wb;
        end else if (wr_en && ph_addr_reg == RDI_INDEX_HIGH_OFS) begin
            index_high_reg <= wb;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page_reg <= RDI_PAGE_RST;
            misc_reg <= RDI_ZERO8;
            mode_reg <= RDI_ZERO8;
            pll_m_reg <= RDI_ZERO8;
        end else if (wr_en && is_ind && index_high_reg == RDI_ZERO8) begin
            unique case (index_reg)
                RDI_IDX_PAGE: page_reg <= wb;
                RDI_IDX_MISC: misc_reg <= wb & RDI_MISC_WMASK;
                RDI_IDX_MODE: mode_reg <= wb;
                RDI_IDX_PLL_M: pll_m_reg <= wb;
                default: ;
            endcase
        end
    end

    // low bytes stage, high byte commits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            x_low_reg <= RDI_ZERO8;
            x_high_reg <= RDI_ZERO8;
            y_low_reg <= RDI_ZERO8;
            y_high_reg <= RDI_ZERO8;
            pointer_pos <= '0;
        end else if (wr_en) begin
            unique case (ph_addr_reg)
                RDI_X_LOW_OFS: x_low_reg <= wb;
                RDI_Y_LOW_OFS: y_low_reg <= wb;
                RDI_X_HIGH_OFS: begin
                    x_high_reg <= wb;
                    pointer_pos.x <= {wb, x_low_reg};
                end
                RDI_Y_HIGH_OFS: begin
                    y_high_reg <= wb;
                    pointer_pos.y <= {wb, y_low_reg};
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // lookup ram: colour bytes in the low 768, pointer bytes above
    // ------------------------------------------------------------
    logic [RDI_RAM_AW-1:0] ram_addr;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [9:0] entry_x3;
    logic [7:0] sel_addr;
    assign sel_addr = ph_write_reg ? wr_addr_reg : rd_addr_reg;
    assign entry_x3 = {2'b00, sel_addr} + {1'b0, sel_addr, 1'b0} + {8'h00, sub_reg};
    assign ram_we = wr_en && (is_data || is_pram);
    // pointer bytes share the ram; a trade of area against a separate array
    assign ram_addr = is_pram ? {1'b1, ram_bank_reg, wr_addr_reg} : {1'b0, entry_x3};

    rdi_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(wb),
        .rdata(ram_rdata)
    );

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    logic [7:0] ind_rd;
    logic [7:0] rd_byte;
    logic [15:0] rd_sel;
    // idle decodes the address phase, so the byte stands when the data phase ends
    assign rd_sel = (state_reg == RDI_IDLE) ? haddr[15:0] : ph_addr_reg;
    always_comb begin
        ind_rd = RDI_ZERO8;
        if (index_high_reg == RDI_ZERO8) begin
            unique case (index_reg)
                RDI_IDX_PAGE: ind_rd = page_reg;
                RDI_IDX_MISC: ind_rd = misc_reg;
                RDI_IDX_MODE: ind_rd = mode_reg;
                default: ind_rd = RDI_ZERO8;
            endcase
        end
    end

    always_comb begin
        rd_byte = RDI_ZERO8;
        unique case (rd_sel)
            RDI_WRITE_ADDR_OFS: rd_byte = wr_addr_reg;
            RDI_READ_MASK_OFS: rd_byte = mask_reg;
            RDI_READ_ADDR_OFS: rd_byte = rd_addr_reg;
            RDI_PCOL_ADDR_OFS: rd_byte = pcol_addr_reg;
            RDI_PCOL_DATA_OFS: rd_byte = pcol_data_reg;
            RDI_INDEX_LOW_OFS: rd_byte = index_reg;
            RDI_INDEX_HIGH_OFS: rd_byte = index_high_reg;
            RDI_INDIRECT_OFS: rd_byte = ind_rd;
            RDI_X_LOW_OFS: rd_byte = x_low_reg;
            RDI_X_HIGH_OFS: rd_byte = x_high_reg;
            RDI_Y_LOW_OFS: rd_byte = y_low_reg;
            RDI_Y_HIGH_OFS: rd_byte = y_high_reg;
            default: rd_byte = RDI_ZERO8;
        endcase
    end

    // ram reads need two wait states because the ram output is registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= RDI_IDLE;
            hreadyout <= 1'b1;
            hrdata <= RDI_ZERO32;
        end else begin
            unique case (state_reg)
                RDI_IDLE: begin
                    if (take && !hwrite && (haddr[15:0] == RDI_DATA_PORT_OFS
                            || haddr[15:0] == RDI_PRAM_DATA_OFS)) begin
                        state_reg <= RDI_RD_WAIT;
                        hreadyout <= 1'b0;
                    end else if (take && !hwrite && wr_en) begin
                        // a write ending now may change the byte; read it a cycle later
                        state_reg <= RDI_RD_DONE;
                        hreadyout <= 1'b0;
                    end else begin
                        hrdata <= {24'h000000, rd_byte};
                    end
                end
                RDI_RD_WAIT: begin
                    state_reg <= RDI_RD_DONE;
                end
                RDI_RD_DONE: begin
                    state_reg <= RDI_IDLE;
                    hreadyout <= 1'b1;
                    hrdata <= {24'h000000, (is_data || is_pram) ? ram_rdata : rd_byte};
                end
                default: state_reg <= RDI_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs toward the display path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
            masked_pixel <= RDI_ZERO8;
            buffer_select <= 1'b0;
        end else begin
            ctrl.converter_power_off <= misc_reg[RDI_MISC_PWR];
            ctrl.lookup_entry_width <= misc_reg[RDI_MISC_WIDTH];
            ctrl.horizontal_sync_invert <= misc_reg[RDI_MISC_HINV];
            ctrl.vertical_sync_invert <= misc_reg[RDI_MISC_VINV];
            ctrl.blanking_pedestal_enable <= misc_reg[RDI_MISC_PED];
            ctrl.green_channel_sync_enable <= misc_reg[RDI_MISC_SOG];
            ctrl.double_buffer_enable <= mode_reg[RDI_MODE_DBUF];
            ctrl.pixel_read_mask <= mask_reg;
            ctrl.overlay_pad_page <= page_reg;
            ctrl.pixel_pll_a_multiplier <= pll_m_reg;
            masked_pixel <= pixel_in[7:0] & mask_reg;
            buffer_select <= mode_reg[RDI_MODE_DBUF] & pixel_in[RDI_PIX_BUF_BIT];
        end
    end

    // okay only; kept in a flop so every output leaves a register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
endmodule : rdi_top

/* rdi_host_model.sv */
// partner: single-transfer ahb-lite host for the register interface
`timescale 1ns/1ns
module rdi_host (
    input wire logic clk, // clock
    input wire logic hreadyout, // slave ready
    input wire logic [31:0] hrdata, // read data
    output logic hsel, // select
    output logic [31:0] haddr, // address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write
    output logic [2:0] hsize, // size
    output logic [31:0] hwdata // write data
);
    import rdi_pkg::*;
    // idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end
    // one whole-word transfer; waits for ready, never assumes a latency
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {16'h0000, a};
        htrans <= RDI_HTRANS_NONSEQ;
        hwrite <= wr;
        #1;
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~haddr;
        hwdata <= {24'h00_0000, d};
        #1;
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        q = hrdata[7:0];
        @(posedge clk);
        // released data no longer shows the old value
        hwdata <= ~hwdata;
    endtask : xfer
endmodule : rdi_host

/* rdi_top_asserts.sv */
// checker: bus timing and output relations of the register interface
`timescale 1ns/1ns
module rdi_chk (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [31:0] pixel_in, // pixel
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire rdi_pkg::rdi_ctrl_s ctrl, // settings
    input wire rdi_pkg::rdi_pos_s pointer_pos, // position
    input wire logic [7:0] masked_pixel, // index
    input wire logic buffer_select // buffer
);
    import rdi_pkg::*;
    localparam logic [15:0] HOLE = 16'h4030;
    logic take;
    logic ram_a;
    logic dwr;
    logic drd;
    logic [15:0] da;
    logic [1:0] up;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // address phase decode
    assign take = hsel && hready && htrans[1];
    assign ram_a = haddr[15:0] == RDI_DATA_PORT_OFS || haddr[15:0] == RDI_PRAM_DATA_OFS;
    // data phase copy; moves only when the bus advances
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dwr <= 1'b0;
            drd <= 1'b0;
            da <= 16'h0000;
        end else if (hready) begin
            dwr <= take && hwrite;
            drd <= take && !hwrite;
            da <= haddr[15:0];
        end
    end
    // edges since reset; hides the jump of ctrl just after release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    // ----------------
    // properties
    // ----------------
    sequence ram_take;
        take && !hwrite && ram_a;
    endsequence
    sequence ram_wait;
        !hreadyout [*2] ##[1:2] hreadyout;
    endsequence
    chk_ram_wait: assert property (ram_take |=> ram_wait)
        else $error("ram read wait wrong");
    chk_fast_answer: assert property (take && (hwrite || (!ram_a && !dwr)) |=> hreadyout)
        else $error("register access stalled");
    chk_late_read: assert property (take && !hwrite && !ram_a && dwr |=> !hreadyout ##1 hreadyout)
        else $error("read after write wait wrong");
    chk_upper_zero: assert property (drd && hready |-> hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    chk_unmapped_zero: assert property (drd && hready && da == HOLE |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_mask_apply: assert property (up == 2'h3 |->
        masked_pixel == ($past(pixel_in[7:0]) & ctrl.pixel_read_mask))
        else $error("mask not applied");
    chk_buffer_pick: assert property (up == 2'h3 |->
        buffer_select == ($past(pixel_in[31]) & ctrl.double_buffer_enable))
        else $error("buffer select wrong");
    chk_pos_cause: assert property ($changed(pointer_pos) |->
        $past(dwr && hready && (da == RDI_X_HIGH_OFS || da == RDI_Y_HIGH_OFS)))
        else $error("position moved without high byte");
    chk_ctrl_cause: assert property (up == 2'h3 && $changed(ctrl) |->
        $past(dwr && hready) || $past(dwr && hready, 2))
        else $error("settings moved without write");
endmodule : rdi_chk
bind rdi_top rdi_chk rdi_chk_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .pixel_in(pixel_in),
    .hrdata(hrdata), .hreadyout(hreadyout), .ctrl(ctrl), .pointer_pos(pointer_pos),
    .masked_pixel(masked_pixel), .buffer_select(buffer_select));

/* tb.sv */
// testbench: register map, settings, pointer position and ram ports
`timescale 1ns/1ns
module tb;
    import rdi_pkg::*;
    typedef struct packed {logic ind; logic [15:0] a; logic [7:0] d; logic [7:0] e;} rdi_row_s;
    localparam rdi_row_s ROWS [13] = '{
        '{1'b0, RDI_READ_MASK_OFS, 8'h5a, 8'h5a}, '{1'b0, RDI_WRITE_ADDR_OFS, 8'h3c, 8'h3c},
        '{1'b0, RDI_READ_ADDR_OFS, 8'hc3, 8'hc3}, '{1'b0, RDI_PCOL_ADDR_OFS, 8'h09, 8'h09},
        '{1'b0, RDI_X_LOW_OFS, 8'h11, 8'h11}, '{1'b0, RDI_X_HIGH_OFS, 8'h02, 8'h02},
        '{1'b0, RDI_Y_LOW_OFS, 8'h22, 8'h22}, '{1'b0, RDI_Y_HIGH_OFS, 8'h01, 8'h01},
        '{1'b0, 16'h4030, 8'h5a, 8'h00}, '{1'b1, 16'h001b, 8'h01, 8'h01},
        '{1'b1, 16'h001c, 8'ha5, 8'ha5}, '{1'b1, 16'h001e, 8'hff, 8'h3f},
        '{1'b1, 16'h0020, 8'h5a, 8'h00}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] pixel_in = 32'h0000_0000;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rdi_ctrl_s ctrl;
    rdi_pos_s pointer_pos;
    logic [7:0] masked_pixel;
    logic buffer_select;
    logic [7:0] rd;
    int num_errors = 0;
    int samples_checked = 0;
    // 100 mhz clock
    always #5 clk = ~clk;
    rdi_top rdi_top_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .pixel_in(pixel_in), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ctrl(ctrl), .pointer_pos(pointer_pos), .masked_pixel(masked_pixel),
        .buffer_select(buffer_select));
    rdi_host rdi_host_i (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ----------------
    // helpers
    // ----------------
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    // indirect access goes index first, then the indirect port
    task automatic ind_wr(input logic [7:0] i, input logic [7:0] d);
        rdi_host_i.xfer(1'b1, RDI_INDEX_LOW_OFS, i, rd);
        rdi_host_i.xfer(1'b1, RDI_INDIRECT_OFS, d, rd);
    endtask : ind_wr
    task automatic ind_rd(input logic [7:0] i);
        rdi_host_i.xfer(1'b1, RDI_INDEX_LOW_OFS, i, rd);
        rdi_host_i.xfer(1'b0, RDI_INDIRECT_OFS, 8'h00, rd);
    endtask : ind_rd
    // let registered outputs land, then look 1 ns after the edge
    task automatic look();
        repeat (3) @(posedge clk);
        #1;
    endtask : look
    task automatic check_resets();
        rdi_host_i.xfer(1'b0, RDI_READ_MASK_OFS, 8'h00, rd);
        chk_byte("mask reset", 8'hff, rd);
        ind_rd(RDI_IDX_PAGE);
        chk_byte("page reset", 8'h00, rd);
        chk_byte("ctrl mask", 8'hff, ctrl.pixel_read_mask);
        chk_byte("ctrl page", 8'h00, ctrl.overlay_pad_page);
        chk_byte("resp", 8'h00, {7'h00, hresp});
    endtask : check_resets
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watchdog far beyond the few hundred cycles of the run
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        check_resets();
        for (int i = 0; i < 13; i++) begin
            if (ROWS[i].ind) begin
                ind_wr(ROWS[i].a[7:0], ROWS[i].d);
                ind_rd(ROWS[i].a[7:0]);
            end else begin
                rdi_host_i.xfer(1'b1, ROWS[i].a, ROWS[i].d, rd);
                rdi_host_i.xfer(1'b0, ROWS[i].a, 8'h00, rd);
            end
            chk_byte("readback", ROWS[i].e, rd);
        end
        look();
        chk_byte("pll m", 8'h5a, ctrl.pixel_pll_a_multiplier);
        chk_byte("page", 8'ha5, ctrl.overlay_pad_page);
        chk_word("x", 16'h0211, pointer_pos.x);
        chk_word("y", 16'h0122, pointer_pos.y);
        // low byte alone must not move the pointer
        rdi_host_i.xfer(1'b1, RDI_X_LOW_OFS, 8'h34, rd);
        look();
        chk_word("x held", 16'h0211, pointer_pos.x);
        rdi_host_i.xfer(1'b1, RDI_X_HIGH_OFS, 8'h03, rd);
        look();
        chk_word("x moved", 16'h0334, pointer_pos.x);
        rdi_host_i.xfer(1'b1, RDI_READ_MASK_OFS, 8'h0f, rd);
        pixel_in <= 32'h8000_00ab;
        look();
        chk_byte("masked", 8'h0b, masked_pixel);
        chk_byte("buffer on", 8'h01, {7'h00, buffer_select});
        ind_wr(RDI_IDX_MODE, 8'h00);
        look();
        chk_byte("buffer off", 8'h00, {7'h00, buffer_select});
        // walking one through the output controls
        for (int b = 0; b < 6; b++) begin
            ind_wr(RDI_IDX_MISC, 8'h01 << b);
            look();
            chk_byte("misc", 8'h01 << b, {2'b00, ctrl.green_channel_sync_enable,
                ctrl.blanking_pedestal_enable, ctrl.vertical_sync_invert,
                ctrl.horizontal_sync_invert, ctrl.lookup_entry_width,
                ctrl.converter_power_off});
        end
        // colour entries go three bytes to an address; small values suit 6-bit width
        rdi_host_i.xfer(1'b1, RDI_WRITE_ADDR_OFS, 8'h05, rd);
        for (int k = 0; k < 3; k++) rdi_host_i.xfer(1'b1, RDI_DATA_PORT_OFS, 8'(8'h10 + k), rd);
        rdi_host_i.xfer(1'b1, RDI_READ_ADDR_OFS, 8'h05, rd);
        for (int k = 0; k < 3; k++) begin
            rdi_host_i.xfer(1'b0, RDI_DATA_PORT_OFS, 8'h00, rd);
            chk_byte("lookup", 8'(8'h10 + k), rd);
        end
        rdi_host_i.xfer(1'b1, RDI_WRITE_ADDR_OFS, 8'h10, rd);
        rdi_host_i.xfer(1'b1, RDI_PRAM_DATA_OFS, 8'h77, rd);
        rdi_host_i.xfer(1'b1, RDI_WRITE_ADDR_OFS, 8'h10, rd);
        rdi_host_i.xfer(1'b0, RDI_PRAM_DATA_OFS, 8'h00, rd);
        chk_byte("pointer ram", 8'h77, rd);
        // second reset in mid-run
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        check_resets();
        report_and_stop();
    end
endmodule : tb
